// ==== rtl/fecm_ctrl.sv ====
// module: host controller issuing extended-mode command sequences to the flash
`timescale 1ns/1ps
`default_nettype none
module fecm_ctrl
  import fecm_pkg::*;
#(
  parameter int RETRY_MAX = 25
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic I_OP_VALID,
  input wire logic [3:0] I_OP_CODE,
  input wire logic [ADDR_W-1:0] I_OP_ADDR,
  input wire logic [DATA_W-1:0] I_OP_DATA,
  output logic O_OP_READY,
  output logic O_DONE,
  output logic O_ERROR,
  output logic [DATA_W-1:0] O_RD_DATA,
  output logic O_MODE_FAST,
  output logic O_MODE_QUERY,
  output logic O_MODE_HIDDEN,
  output logic O_PROTECTED,
  output logic [ADDR_W-1:0] O_FL_ADDR,
  output logic [DATA_W-1:0] O_FL_DQ,
  output logic O_FL_DQ_OE,
  input wire logic [DATA_W-1:0] I_FL_DQ,
  output logic O_FL_CE_N,
  output logic O_FL_WE_N,
  output logic O_FL_OE_N,
  output logic O_FL_RESET_N,
  input wire logic I_FL_READY_BUSY
);
  fecm_state_t st_q, st_d;
  fecm_op_t op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic [2:0] step_q, step_d;
  logic fast_q, fast_d;
  logic query_q, query_d;
  logic hid_q, hid_d;
  logic prot_q, prot_d;
  logic tog_q, tog_d;
  logic have_tog_q, have_tog_d;
  logic [7:0] retry_q, retry_d;
  logic [7:0] cnt_q, cnt_d;
  logic rst_n_q, rst_n_d;
  logic ready_q, ready_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic [DATA_W-1:0] rd_q, rd_d;
  logic start_q, start_d;
  logic ewr_q, ewr_d;
  logic [ADDR_W-1:0] eaddr_q, eaddr_d;
  logic [DATA_W-1:0] edata_q, edata_d;
  logic eng_done;
  logic [DATA_W-1:0] eng_rd;
  logic s_wr;
  logic s_last;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;
  logic [2:0] idx;
  logic refuse;
  fecm_op_t in_op;

  function automatic logic [ADDR_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
    bank_of = {a[ADDR_W-1:BANK_LSB], {BANK_LSB{1'b0}}};
  endfunction : bank_of

  function automatic logic in_hidden(input logic [ADDR_W-1:0] a);
    in_hidden = (a >= HIDDEN_BASE) && (a < HIDDEN_BASE + HIDDEN_WORDS);
  endfunction : in_hidden

  // ==========================================================
  // command step table
  always_comb
  begin
    s_wr = 1'b1;
    s_last = 1'b0;
    s_addr = UNLOCK1_ADDR;
    s_data = UNLOCK1_DATA;
    idx = (op_q == OP_PROGRAM && fast_q) ? step_q + 3'h2 : step_q;
    case (op_q)
      OP_PROGRAM, OP_FAST_ENTER, OP_HIDDEN_ENTER, OP_HIDDEN_EXIT:
      begin
        case (idx)
          3'h0:
          begin
            s_addr = UNLOCK1_ADDR;
          end
          3'h1:
          begin
            s_addr = UNLOCK2_ADDR;
            s_data = UNLOCK2_DATA;
          end
          3'h2:
          begin
            s_addr = UNLOCK1_ADDR;
            s_data = (op_q == OP_PROGRAM) ? CMD_PROGRAM :
                     (op_q == OP_FAST_ENTER) ? CMD_FAST_ENTER :
                     (op_q == OP_HIDDEN_ENTER) ? CMD_HIDDEN_ENTER : CMD_HIDDEN_EXIT1;
            if (op_q == OP_HIDDEN_EXIT)
            begin
              s_addr = FIRST_BANK_BASE | UNLOCK1_ADDR;
            end
            s_last = (op_q == OP_FAST_ENTER) || (op_q == OP_HIDDEN_ENTER);
          end
          default:
          begin
            s_addr = (op_q == OP_PROGRAM) ? addr_q : FIRST_BANK_BASE;
            s_data = (op_q == OP_PROGRAM) ? data_q : CMD_HIDDEN_EXIT2;
            s_last = 1'b1;
          end
        endcase
      end
      OP_FAST_EXIT:
      begin
        s_addr = bank_of(addr_q);
        s_data = (step_q == 3'h0) ? CMD_FAST_EXIT1 : CMD_FAST_EXIT2;
        s_last = (step_q != 3'h0);
      end
      OP_QUERY:
      begin
        s_addr = bank_of(addr_q) | QUERY_ADDR;
        s_data = CMD_QUERY;
        s_last = 1'b1;
      end
      OP_READ_RESET:
      begin
        s_data = CMD_READ_RESET;
        s_last = 1'b1;
      end
      OP_PROTECT:
      begin
        s_addr = (HIDDEN_BASE & ~ADDR_W'(PROTECT_LOW_MASK)) | ADDR_W'(PROTECT_LOW_PATTERN);
        s_data = CMD_PROTECT;
        s_wr = (step_q != 3'h2);
        s_last = (step_q == 3'h2);
      end
      default:
      begin
        s_addr = addr_q;
        s_wr = 1'b0;
        s_last = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // request screening
  always_comb
  begin
    in_op = fecm_op_t'(I_OP_CODE);
    refuse = 1'b0;
    if (fast_q && !(in_op == OP_PROGRAM || in_op == OP_READ || in_op == OP_FAST_EXIT))
    begin
      refuse = 1'b1;
    end
    if (in_op == OP_PROTECT && !hid_q)
    begin
      refuse = 1'b1;
    end
    if (in_op == OP_PROGRAM && hid_q && (!in_hidden(I_OP_ADDR) || prot_q))
    begin
      refuse = 1'b1;
    end
    if (I_OP_CODE > 4'h9)
    begin
      refuse = 1'b1;
    end
  end

  // ==========================================================
  // sequencer
  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    step_d = step_q;
    fast_d = fast_q;
    query_d = query_q;
    hid_d = hid_q;
    prot_d = prot_q;
    tog_d = tog_q;
    have_tog_d = have_tog_q;
    retry_d = retry_q;
    cnt_d = cnt_q;
    rst_n_d = rst_n_q;
    done_d = 1'b0;
    err_d = 1'b0;
    rd_d = rd_q;
    start_d = 1'b0;
    ewr_d = ewr_q;
    eaddr_d = eaddr_q;
    edata_d = edata_q;
    case (st_q)
      ST_IDLE:
      begin
        if (I_OP_VALID)
        begin
          op_d = in_op;
          addr_d = I_OP_ADDR;
          data_d = I_OP_DATA;
          step_d = 3'h0;
          retry_d = 8'h00;
          if (refuse)
          begin
            err_d = 1'b1;
            done_d = 1'b1;
          end
          else if (in_op == OP_HW_RESET)
          begin
            st_d = ST_RESET;
            rst_n_d = 1'b0;
            cnt_d = 8'(RST_CYC + RDY_CYC);
          end
          else
          begin
            st_d = ST_ISSUE;
          end
        end
      end
      ST_ISSUE:
      begin
        start_d = 1'b1;
        ewr_d = s_wr;
        eaddr_d = s_addr;
        edata_d = s_data;
        st_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (eng_done)
        begin
          if (!s_last)
          begin
            step_d = step_q + 3'h1;
            st_d = ST_ISSUE;
          end
          else if (op_q == OP_PROGRAM)
          begin
            have_tog_d = 1'b0;
            st_d = ST_POLL;
          end
          else if (op_q == OP_PROTECT && !eng_rd[VERIFY_BIT] && retry_q < 8'(RETRY_MAX))
          begin
            retry_d = retry_q + 8'h01;
            step_d = 3'h0;
            st_d = ST_ISSUE;
          end
          else
          begin
            st_d = ST_IDLE;
            done_d = 1'b1;
            rd_d = eng_rd;
            case (op_q)
              OP_FAST_ENTER: fast_d = 1'b1;
              OP_FAST_EXIT: fast_d = 1'b0;
              OP_QUERY: query_d = 1'b1;
              OP_READ_RESET: query_d = 1'b0;
              OP_HIDDEN_ENTER: hid_d = 1'b1;
              OP_HIDDEN_EXIT: hid_d = 1'b0;
              OP_PROTECT:
              begin
                prot_d = eng_rd[VERIFY_BIT];
                err_d = ~eng_rd[VERIFY_BIT];
              end
              default: rd_d = eng_rd;
            endcase
          end
        end
      end
      ST_POLL:
      begin
        start_d = 1'b1;
        ewr_d = 1'b0;
        eaddr_d = addr_q;
        st_d = ST_POLL_WAIT;
      end
      ST_POLL_WAIT:
      begin
        if (eng_done)
        begin
          tog_d = eng_rd[TOGGLE_BIT];
          have_tog_d = 1'b1;
          if (have_tog_q && eng_rd[TOGGLE_BIT] == tog_q && I_FL_READY_BUSY)
          begin
            st_d = ST_IDLE;
            done_d = 1'b1;
            rd_d = eng_rd;
            err_d = (eng_rd != data_q);
          end
          else
          begin
            st_d = ST_POLL;
          end
        end
      end
      ST_RESET:
      begin
        fast_d = 1'b0;
        query_d = 1'b0;
        hid_d = 1'b0;
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'(RDY_CYC))
        begin
          rst_n_d = 1'b1;
        end
        if (cnt_q == 8'h00)
        begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
    ready_d = (st_d == ST_IDLE);
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      st_q <= ST_IDLE;
      op_q <= OP_READ;
      addr_q <= '0;
      data_q <= '0;
      step_q <= 3'h0;
      fast_q <= 1'b0;
      query_q <= 1'b0;
      hid_q <= 1'b0;
      prot_q <= 1'b0;
      tog_q <= 1'b0;
      have_tog_q <= 1'b0;
      retry_q <= 8'h00;
      cnt_q <= 8'h00;
      rst_n_q <= 1'b1;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      err_q <= 1'b0;
      rd_q <= '0;
      start_q <= 1'b0;
      ewr_q <= 1'b0;
      eaddr_q <= '0;
      edata_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      step_q <= step_d;
      fast_q <= fast_d;
      query_q <= query_d;
      hid_q <= hid_d;
      prot_q <= prot_d;
      tog_q <= tog_d;
      have_tog_q <= have_tog_d;
      retry_q <= retry_d;
      cnt_q <= cnt_d;
      rst_n_q <= rst_n_d;
      ready_q <= ready_d;
      done_q <= done_d;
      err_q <= err_d;
      rd_q <= rd_d;
      start_q <= start_d;
      ewr_q <= ewr_d;
      eaddr_q <= eaddr_d;
      edata_q <= edata_d;
    end
  end

  fecm_bus_cycle u_cycle (
    .i_clk(I_CLK_SYS),
    .i_srst(I_SRST),
    .i_start(start_q),
    .i_write(ewr_q),
    .i_addr(eaddr_q),
    .i_data(edata_q),
    .i_dq(I_FL_DQ),
    .o_done(eng_done),
    .o_rd_data(eng_rd),
    .o_addr(O_FL_ADDR),
    .o_dq(O_FL_DQ),
    .o_dq_oe(O_FL_DQ_OE),
    .o_ce_n(O_FL_CE_N),
    .o_we_n(O_FL_WE_N),
    .o_oe_n(O_FL_OE_N)
  );

  assign O_OP_READY = ready_q;
  assign O_DONE = done_q;
  assign O_ERROR = err_q;
  assign O_RD_DATA = rd_q;
  assign O_MODE_FAST = fast_q;
  assign O_MODE_QUERY = query_q;
  assign O_MODE_HIDDEN = hid_q;
  assign O_PROTECTED = prot_q;
  assign O_FL_RESET_N = rst_n_q;
endmodule : fecm_ctrl
`default_nettype wire

// ==== include/fecm_pkg.sv ====
// package: constants for the extended-mode flash command controller
// Operation
// - never issue erase while in fast mode
// - fast reset, bank address on first cycle
// - drive bank bits when writing query command
// - read/reset command ends query mode
// - change address or chip select before read
// - exit sequence, bank address on third cycle
// - program only inside hidden region in hidden mode
// - protect: set-up, protect code, pattern address
// - protect address must lie in hidden region
package fecm_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 25;
  // ==========================================================
  // bus timing
  localparam int T_SETUP_NS = 25;
  localparam int T_WRITE_PULSE_NS = 50;
  localparam int T_ACCESS_NS = 90;
  localparam int T_RECOVER_NS = 30;
  localparam int T_RESET_PULSE_NS = 500;
  localparam int T_RESET_READY_NS = 500;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC = (T_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RDY_CYC = (T_RESET_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // command cycles (word addresses)
  localparam logic [21:0] UNLOCK1_ADDR = 22'h000555;
  localparam logic [21:0] UNLOCK2_ADDR = 22'h0002AA;
  localparam logic [21:0] QUERY_ADDR = 22'h000055;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [15:0] CMD_FAST_ENTER = 16'h0020;
  localparam logic [15:0] CMD_FAST_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_FAST_EXIT2 = 16'h00F0;
  localparam logic [15:0] CMD_QUERY = 16'h0098;
  localparam logic [15:0] CMD_READ_RESET = 16'h00F0;
  localparam logic [15:0] CMD_HIDDEN_ENTER = 16'h0088;
  localparam logic [15:0] CMD_HIDDEN_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_HIDDEN_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_PROTECT = 16'h0060;
  // ==========================================================
  // address map: bank bits, hidden region (256 bytes = 128 words)
  localparam int BANK_LSB = 19;
  localparam logic [21:0] FIRST_BANK_BASE = 22'h000000;
  localparam logic [21:0] HIDDEN_BASE = 22'h000000;
  localparam logic [21:0] HIDDEN_WORDS = 22'h000080;
  localparam logic [6:0] PROTECT_LOW_MASK = 7'h4F;
  localparam logic [6:0] PROTECT_LOW_PATTERN = 7'h02;
  localparam int VERIFY_BIT = 0;
  localparam int TOGGLE_BIT = 6;
  // ==========================================================
  // user operations and controller states
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_FAST_ENTER = 4'h2,
    OP_FAST_EXIT = 4'h3,
    OP_QUERY = 4'h4,
    OP_READ_RESET = 4'h5,
    OP_HIDDEN_ENTER = 4'h6,
    OP_HIDDEN_EXIT = 4'h7,
    OP_PROTECT = 4'h8,
    OP_HW_RESET = 4'h9
  } fecm_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ISSUE = 3'h1,
    ST_WAIT = 3'h2,
    ST_POLL = 3'h3,
    ST_POLL_WAIT = 3'h4,
    ST_RESET = 3'h5
  } fecm_state_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_SETUP = 2'h1,
    PH_STROBE = 2'h2,
    PH_RECOVER = 2'h3
  } fecm_phase_t;
endpackage : fecm_pkg

// ==== rtl/fecm_bus_cycle.sv ====
// module: one asynchronous flash bus cycle (write or read) per start pulse
`timescale 1ns/1ps
`default_nettype none
module fecm_bus_cycle
  import fecm_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [DATA_W-1:0] i_dq,
  output logic o_done,
  output logic [DATA_W-1:0] o_rd_data,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n
);
  fecm_phase_t ph_q, ph_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic done_q, done_d;
  logic [DATA_W-1:0] rd_q, rd_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] dq_q, dq_d;
  logic dq_oe_q, dq_oe_d;
  logic ce_n_q, ce_n_d;
  logic we_n_q, we_n_d;
  logic oe_n_q, oe_n_d;

  // ==========================================================
  // phase sequencing: chip select rises between every cycle
  always_comb
  begin
    ph_d = ph_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    done_d = 1'b0;
    rd_d = rd_q;
    addr_d = addr_q;
    dq_d = dq_q;
    dq_oe_d = dq_oe_q;
    ce_n_d = ce_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    case (ph_q)
      PH_IDLE:
      begin
        if (i_start)
        begin
          ph_d = PH_SETUP;
          cnt_d = CNT_W'(SETUP_CYC - 1);
          wr_d = i_write;
          addr_d = i_addr;
          dq_d = i_data;
          dq_oe_d = i_write;
          ce_n_d = 1'b0;
        end
      end
      PH_SETUP:
      begin
        if (cnt_q == '0)
        begin
          ph_d = PH_STROBE;
          cnt_d = wr_q ? CNT_W'(WP_CYC - 1) : CNT_W'(ACC_CYC - 1);
          we_n_d = ~wr_q;
          oe_n_d = wr_q;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      PH_STROBE:
      begin
        if (cnt_q == '0)
        begin
          ph_d = PH_RECOVER;
          cnt_d = CNT_W'(REC_CYC - 1);
          if (!wr_q)
          begin
            rd_d = i_dq;
          end
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          ce_n_d = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      PH_RECOVER:
      begin
        if (cnt_q == '0)
        begin
          ph_d = PH_IDLE;
          dq_oe_d = 1'b0;
          done_d = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default:
      begin
        ph_d = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ph_q <= PH_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      rd_q <= '0;
      addr_q <= '0;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
    end
    else
    begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      done_q <= done_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign o_done = done_q;
  assign o_rd_data = rd_q;
  assign o_addr = addr_q;
  assign o_dq = dq_q;
  assign o_dq_oe = dq_oe_q;
  assign o_ce_n = ce_n_q;
  assign o_we_n = we_n_q;
  assign o_oe_n = oe_n_q;
endmodule : fecm_bus_cycle
`default_nettype wire

// ==== test/fecm_ctrl_sva.sv ====
// checker: port-level assertions for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module fecm_ctrl_sva
  import fecm_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic I_OP_VALID,
  input wire logic [3:0] I_OP_CODE,
  input wire logic [ADDR_W-1:0] I_OP_ADDR,
  input wire logic O_OP_READY,
  input wire logic O_DONE,
  input wire logic O_ERROR,
  input wire logic O_MODE_FAST,
  input wire logic O_MODE_HIDDEN,
  input wire logic O_FL_CE_N,
  input wire logic O_FL_WE_N,
  input wire logic O_FL_OE_N,
  input wire logic O_FL_RESET_N
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);
  logic take;
  assign take = I_OP_VALID && O_OP_READY;
  // ==========================================================
  // strobe shapes
  sequence s_wr_pulse;
    !O_FL_WE_N [*2] ##1 O_FL_WE_N;
  endsequence
  sequence s_rd_pulse;
    !O_FL_OE_N [*4] ##1 O_FL_OE_N;
  endsequence
  AST_WR_PULSE: assert property ($fell(O_FL_WE_N) |-> s_wr_pulse)
    else $error("write pulse length wrong");
  AST_RD_PULSE: assert property ($fell(O_FL_OE_N) |-> s_rd_pulse)
    else $error("read strobe length wrong");
  AST_CE_BEFORE_OE: assert property ($fell(O_FL_OE_N) |-> !$past(O_FL_CE_N) && $past(O_FL_CE_N, 2))
    else $error("read without fresh chip select");
  AST_IDLE_BUS: assert property (O_OP_READY |-> O_FL_CE_N && O_FL_WE_N && O_FL_OE_N)
    else $error("bus active while ready");
  AST_RST_PULSE: assert property ($fell(O_FL_RESET_N) |-> !O_FL_RESET_N [*8])
    else $error("device reset pulse too short");
  // ==========================================================
  // request handling
  AST_ERR_DONE: assert property (O_ERROR |-> O_DONE)
    else $error("error without done");
  AST_BAD_CODE: assert property (take && I_OP_CODE > 4'h9 |=> O_DONE && O_ERROR)
    else $error("bad code not refused");
  AST_READ_BUSY: assert property (take && I_OP_CODE == OP_READ |=> !O_OP_READY)
    else $error("read not started");
  AST_FAST_REFUSE: assert property (take && O_MODE_FAST && I_OP_CODE == OP_QUERY |=> O_DONE && O_ERROR)
    else $error("command in fast mode not refused");
  AST_HID_RANGE: assert property (take && O_MODE_HIDDEN && I_OP_CODE == OP_PROGRAM
      && I_OP_ADDR >= HIDDEN_WORDS |=> O_DONE && O_ERROR)
    else $error("program outside region not refused");
  AST_PROT_OUT: assert property (take && !O_MODE_HIDDEN && I_OP_CODE == OP_PROTECT |=> O_DONE && O_ERROR)
    else $error("protect outside hidden mode not refused");
endmodule : fecm_ctrl_sva
bind fecm_ctrl fecm_ctrl_sva fecm_ctrl_sva_i (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST),
  .I_OP_VALID(I_OP_VALID), .I_OP_CODE(I_OP_CODE), .I_OP_ADDR(I_OP_ADDR),
  .O_OP_READY(O_OP_READY), .O_DONE(O_DONE), .O_ERROR(O_ERROR), .O_MODE_FAST(O_MODE_FAST),
  .O_MODE_HIDDEN(O_MODE_HIDDEN), .O_FL_CE_N(O_FL_CE_N), .O_FL_WE_N(O_FL_WE_N),
  .O_FL_OE_N(O_FL_OE_N), .O_FL_RESET_N(O_FL_RESET_N));
`default_nettype wire

// ==== test/fecm_flash_model.sv ====
// model: behavioural flash device with extended command modes
`timescale 1ns/1ps
`default_nettype none
module fecm_flash_model
  import fecm_pkg::*;
(
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_reset_n,
  output logic [DATA_W-1:0] o_dq,
  output logic o_ready_busy
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] otp [128];
  logic [ADDR_W-1:0] a1, a2;
  logic [DATA_W-1:0] d1, d2, rd, last;
  logic fast, hid, qry, prot, pgm, vfy, tog, unl;
  logic [2:0] qbank;
  int busy;
  initial
  begin
    {fast, hid, qry, prot, pgm, vfy, tog} = 7'h00;
    {a1, a2, d1, d2, rd, last, qbank} = 'h0;
    busy = 0;
    for (int i = 0; i < 128; i++) otp[i] = 16'hFFFF;
  end
  // ==========================================================
  // command decode, latched at the write strobe
  always @(negedge i_we_n or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      {fast, hid, qry, pgm, vfy} = 5'h00;
    end
    else if (!i_ce_n)
    begin
      unl = a2[11:0] == 12'h555 && d2 == 16'h00AA && a1[11:0] == 12'h2AA && d1 == 16'h0055;
      vfy = 1'b0;
      if (pgm)
      begin
        pgm = 1'b0;
        busy = 3;
        if (hid && i_addr < 128)
        begin
          if (!prot) otp[i_addr[6:0]] = i_dq;
        end
        else mem[i_addr] = i_dq;
      end
      else if (fast)
      begin
        if (i_dq == CMD_PROGRAM) pgm = 1'b1;
        else if (d1 == CMD_FAST_EXIT1 && i_dq == CMD_FAST_EXIT2) fast = 1'b0;
      end
      else if (hid && d1 == CMD_HIDDEN_EXIT1 && i_dq == CMD_HIDDEN_EXIT2) hid = 1'b0;
      else if (hid && i_dq == CMD_PROTECT && d1 == CMD_PROTECT && i_addr[6:0] == 7'h02)
      begin
        prot = 1'b1;
        vfy = 1'b1;
      end
      else if (unl && i_dq == CMD_PROGRAM) pgm = 1'b1;
      else if (unl && i_dq == CMD_FAST_ENTER) fast = 1'b1;
      else if (unl && i_dq == CMD_HIDDEN_ENTER) hid = 1'b1;
      else if (i_dq == CMD_QUERY && i_addr[11:0] == 12'h055)
      begin
        qry = 1'b1;
        qbank = i_addr[21:19];
      end
      else if (i_dq == CMD_READ_RESET) qry = 1'b0;
      {a2, d2, a1, d1} = {a1, d1, i_addr, i_dq};
    end
  end
  // ==========================================================
  // read data; a released bus shows the inverse of the last value
  always @(negedge i_oe_n)
  begin
    if (busy > 0)
    begin
      busy = busy - 1;
      tog = ~tog;
      rd = {9'h000, tog, 6'h00};
    end
    else if (vfy && i_addr[6:0] == 7'h02) rd = {15'h0000, prot};
    else if (qry && i_addr[21:19] == qbank) rd = 16'h0051;
    else if (hid && i_addr < 128) rd = otp[i_addr[6:0]];
    else rd = mem.exists(i_addr) ? mem[i_addr] : 16'hFFFF;
  end
  always @(posedge i_oe_n) last = rd;
  assign o_dq = (i_oe_n || i_ce_n) ? ~last : rd;
  assign o_ready_busy = busy == 0;
endmodule : fecm_flash_model
`default_nettype wire

// ==== test/flash_extended_command_modes_test.sv ====
// testbench: controller driven through its user port against the device model
`timescale 1ns/1ps
`default_nettype none
module flash_extended_command_modes_test;
  import fecm_pkg::*;
  logic clk, srst, valid;
  logic [3:0] code;
  logic [ADDR_W-1:0] addr, fl_addr;
  logic [DATA_W-1:0] data, rdd, fl_dq, host_dq, dev_dq, rd;
  logic ready, done, err, er, mf, mq, mh, prot, dq_oe, ce_n, we_n, oe_n, rst_n, rb;
  int fails, num_checks, wr, cyc;
  logic [ADDR_W-1:0] wa [$];
  assign fl_dq = dq_oe ? host_dq : dev_dq;
  fecm_ctrl #(.RETRY_MAX(2)) fecm_ctrl_i (.I_CLK_SYS(clk), .I_SRST(srst), .I_OP_VALID(valid),
    .I_OP_CODE(code), .I_OP_ADDR(addr), .I_OP_DATA(data), .O_OP_READY(ready), .O_DONE(done),
    .O_ERROR(err), .O_RD_DATA(rdd), .O_MODE_FAST(mf), .O_MODE_QUERY(mq), .O_MODE_HIDDEN(mh),
    .O_PROTECTED(prot), .O_FL_ADDR(fl_addr), .O_FL_DQ(host_dq), .O_FL_DQ_OE(dq_oe),
    .I_FL_DQ(fl_dq), .O_FL_CE_N(ce_n), .O_FL_WE_N(we_n), .O_FL_OE_N(oe_n),
    .O_FL_RESET_N(rst_n), .I_FL_READY_BUSY(rb));
  fecm_flash_model fecm_flash_model_i (.i_addr(fl_addr), .i_dq(fl_dq), .i_ce_n(ce_n),
    .i_we_n(we_n), .i_oe_n(oe_n), .i_reset_n(rst_n), .o_dq(dev_dq), .o_ready_busy(rb));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge we_n)
  begin
    wr++;
    wa.push_back(fl_addr);
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic op(input logic [3:0] c, input logic [21:0] a, input logic [15:0] d);
    int n;
    @(negedge clk);
    valid = 1'b1;
    {code, addr, data} = {c, a, d};
    wr = 0;
    wa.delete();
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk(n < 3000, "no done");
    rd = rdd;
    er = err;
  endtask : op
  task automatic rchk(input logic [21:0] a, input logic [15:0] exp, input string m);
    op(4'h0, a, 16'h0000);
    chk(rd === exp && er === 1'b0, m);
  endtask : rchk
  task automatic final_report;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      final_report();
    end
  end
  // ==========================================================
  // tests
  initial
  begin
    {srst, valid, code, addr, data} = {1'b1, 1'b0, 4'h0, 22'h0, 16'h0};
    repeat (12) @(negedge clk);
    srst = 1'b0;
    chk(ready === 1'b1 && mf === 1'b0 && mh === 1'b0 && ce_n === 1'b1 && rst_n === 1'b1, "reset");
    op(4'h1, 22'h000080, 16'h1234);
    chk(wr == 4 && er === 1'b0, "normal program");
    rchk(22'h000080, 16'h1234, "normal readback");
    $display("test normal done");
    op(4'h2, 22'h0, 16'h0);
    chk(mf === 1'b1 && wr == 3, "fast enter");
    op(4'h1, 22'h002001, 16'h5A5A);
    chk(wr == 2 && er === 1'b0, "fast program cycles");
    rchk(22'h002001, 16'h5A5A, "fast readback");
    op(4'h4, 22'h080000, 16'h0);
    chk(er === 1'b1 && wr == 0, "query refused in fast");
    op(4'h3, 22'h100000, 16'h0);
    chk(mf === 1'b0 && wa.size() == 2 && wa[0] === 22'h100000, "fast exit");
    $display("test fast done");
    op(4'h4, 22'h080000, 16'h0);
    chk(mq === 1'b1 && wa.size() == 1 && wa[0][21:19] === 3'h1, "query enter");
    rchk(22'h080010, 16'h0051, "query info upper byte zero");
    rchk(22'h000080, 16'h1234, "other bank array");
    op(4'h5, 22'h0, 16'h0);
    chk(mq === 1'b0, "read reset");
    rchk(22'h080010, 16'hFFFF, "array after query");
    $display("test query done");
    op(4'h6, 22'h0, 16'h0);
    chk(mh === 1'b1 && wr == 3, "hidden enter");
    op(4'h1, 22'h000010, 16'hC3C3);
    chk(er === 1'b0 && wr == 4, "hidden program");
    rchk(22'h000010, 16'hC3C3, "hidden readback");
    rchk(22'h000080, 16'h1234, "region end boundary");
    op(4'h1, 22'h000100, 16'h0000);
    chk(er === 1'b1 && wr == 0, "program outside region");
    op(4'h8, 22'h000002, 16'h0);
    chk(er === 1'b0 && prot === 1'b1 && wa.size() == 2 && wa[1][6:0] === 7'h02, "protect");
    op(4'h1, 22'h000011, 16'h0000);
    chk(er === 1'b1 && wr == 0, "program after protect");
    rchk(22'h000011, 16'hFFFF, "protected word unchanged");
    op(4'h7, 22'h0, 16'h0);
    chk(mh === 1'b0 && wa.size() == 4 && wa[2][21:19] === 3'h0, "hidden exit");
    rchk(22'h000010, 16'hFFFF, "array after exit");
    $display("test hidden done");
    op(4'h8, 22'h000002, 16'h0);
    chk(er === 1'b1 && wr == 0, "protect outside hidden");
    op(4'hA, 22'h0, 16'h0);
    chk(er === 1'b1 && wr == 0, "bad code");
    op(4'h6, 22'h0, 16'h0);
    op(4'h9, 22'h0, 16'h0);
    chk(mh === 1'b0 && mf === 1'b0 && rst_n === 1'b1, "hw reset");
    rchk(22'h000010, 16'hFFFF, "normal sector after reset");
    $display("test reset done");
    final_report();
  end
endmodule : flash_extended_command_modes_test
`default_nettype wire
